/* File: logic/runaway_watchdog_pkg.sv */
// shared constants and carrier types for the runaway watchdog
package runaway_watchdog_pkg;

    // counter widths
    localparam int unsigned PRESCALE_WIDTH = 12;
    localparam int unsigned WDOG_WIDTH     = 6;

    // nominal timeouts in oscillator cycles, per period select value
    localparam int unsigned LONG_TIMEOUT_CYCLES  = 262128;
    localparam int unsigned SHORT_TIMEOUT_CYCLES = 8176;
    // watchdog count at which a prescaler wrap overflows the watchdog
    localparam logic [5:0]  WDOG_LAST_LONG  = 6'h3F;
    localparam logic [5:0]  WDOG_LAST_SHORT = 6'h01;
    // prescaler stages 12..5 are bits 11..4
    localparam int unsigned SERVICE_CLR_LSB = 4;

    // power-up delay before the prescaler is cleared
    localparam int unsigned POR_CLEAR_CYCLES = 4096;
    // reset pin low time
    localparam int unsigned PIN_LOW_CYCLES   = 32;

    // register offsets
    localparam logic [15:0] SERVICE_ADDR    = 16'hFFFF;
    localparam logic [15:0] FIRST_CONFIG_REG_ADDR    = 16'h001F;
    localparam logic [15:0] PIN_CTRL_ADDR   = 16'h0040;
    localparam logic [15:0] EVT_STATUS_ADDR = 16'h0041;
    localparam logic [15:0] EVT_MASK_ADDR   = 16'h0042;
    localparam logic [15:0] CAUSE_ADDR      = 16'h0043;

    // field positions
    localparam int unsigned CFG_PERIOD_BIT = 7;
    localparam int unsigned CFG_OFF_BIT    = 0;
    localparam int unsigned PIN_FUNC_BIT   = 0;
    localparam int unsigned CAUSE_BIT      = 0;
    localparam int unsigned EVT_TIMEOUT    = 0;
    localparam int unsigned EVT_SERVICE    = 1;

    // values after reset
    localparam logic [7:0]  FIRST_CONFIG_REG_RESET  = 8'h00;
    localparam logic [1:0]  EVT_RESET      = 2'h0;

    // register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

    // operating conditions from the rest of the chip
    typedef struct packed {
        logic stop_mode;
        logic wait_mode;
        logic monitor_mode;
        logic break_active;
        logic break_watchdog_off;
        logic internal_reset;
    } mode_type;

endpackage : runaway_watchdog_pkg

/* File: logic/runaway_watchdog.sv */
// runaway code watchdog with its prescaler, reset pin driver and registers
// Summary of operation
// - 6-bit counter advanced by 12-bit prescaler wrap
// - unserviced overflow resets after long or short period
// - any write to service outside stop clears counter, prescaler 12..5
// - timeout sets cause bit, pin low 32 cycles
// - service read returns reset vector low byte
// - stop instruction clears the prescaler
// - prescaler cleared 4096 cycles after power-up
// - internal reset clears prescaler and watchdog counter
// - disable input follows config off bit
// - off bit set means never reset
// - period select 1 short, 0 long
// - timeout resets and sets timeout event flag for event_irq
// - disabled in monitor mode with test voltage
// - keeps counting during wait mode
// - stop gates watchdog clock, clears prescaler
// - break in monitor mode with break bit disables
// - counts on the oscillator output clock
`timescale 1ns/1ps
`default_nettype none
module runaway_watchdog
    import runaway_watchdog_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CLEAR_CYCLES
) (
    // clock and power-on reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register port
    input  wire bus_req_type bus_req,
    output var  logic [7:0]  bus_rdata,
    input  wire logic [7:0]  reset_vector_lo,
    // chip operating modes
    input  wire mode_type    mode,
    input  wire logic        test_high_voltage,
    // reset outputs
    output var  logic        wdog_reset,
    output var  logic        reset_pin_o,
    output var  logic        reset_pin_oe,
    output var  logic        reset_cause,
    // event summary output
    output var  logic        event_irq
);

    typedef struct packed {
        logic [PRESCALE_WIDTH-1:0] pre;
        logic [WDOG_WIDTH-1:0]     cnt;
        logic [12:0]               por_cnt;
        logic                      por_done;
        logic [5:0]                pin_cnt;
        logic                      pin_oe;
        logic                      reset_out;
        logic [7:0]                first_config_reg;
        logic                      cfg_locked;
        logic                      pin_func;
        logic                      cause;
        logic [1:0]                evt_status;
        logic [1:0]                evt_mask;
        logic                      irq;
        logic [7:0]                rdata;
        logic                      hv_meta;
        logic                      hv_sync;
    } state_type;

    state_type s_q;
    state_type s_d;

    // decode helper used for both strobes
    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        hit = (a == b);
    endfunction : hit

    logic wr_service;
    logic rd_service;
    logic disabled;
    logic tick;
    logic expire;
    logic [WDOG_WIDTH-1:0] last_cnt;

    always_comb begin
        wr_service = bus_req.wr && hit(bus_req.addr, SERVICE_ADDR);
        rd_service = bus_req.rd && hit(bus_req.addr, SERVICE_ADDR);
        disabled = s_q.first_config_reg[CFG_OFF_BIT]
                 || (mode.monitor_mode && s_q.hv_sync)
                 || (mode.monitor_mode && mode.break_active
                     && mode.break_watchdog_off);
        last_cnt = s_q.first_config_reg[CFG_PERIOD_BIT] ? WDOG_LAST_SHORT
                                                : WDOG_LAST_LONG;
        tick = (s_q.pre == {PRESCALE_WIDTH{1'b1}});
        // no clock to watchdog in stop
        // wait mode does not stop it
        expire = tick && (s_q.cnt == last_cnt) && !disabled
               && !mode.stop_mode && !s_q.pin_oe;
    end

    always_comb begin
        s_d = s_q;
        s_d.hv_meta = test_high_voltage;
        s_d.hv_sync = s_q.hv_meta;
        s_d.rdata   = 8'h00;

        s_d.pre = s_q.pre + 1'b1;
        if (tick && !disabled) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
        if (disabled) begin
            s_d.cnt = '0;
        end

        if (!s_q.por_done) begin
            s_d.por_cnt = s_q.por_cnt + 1'b1;
            if (s_q.por_cnt == 13'(POR_CYCLES - 1)) begin
                s_d.por_done = 1'b1;
                s_d.pre      = '0;
            end
        end

        if (wr_service) begin
            s_d.cnt = '0;
            s_d.pre[PRESCALE_WIDTH-1:SERVICE_CLR_LSB] = '0;
        end

        if (mode.stop_mode) begin
            s_d.pre = '0;
            s_d.cnt = s_q.cnt;
        end

        // register writes; config is write-once after each reset
        if (bus_req.wr) begin
            if (hit(bus_req.addr, FIRST_CONFIG_REG_ADDR) && !s_q.cfg_locked) begin
                s_d.first_config_reg    = bus_req.wdata;
                s_d.cfg_locked = 1'b1;
            end
            if (hit(bus_req.addr, PIN_CTRL_ADDR)) begin
                s_d.pin_func = bus_req.wdata[PIN_FUNC_BIT];
            end
            if (hit(bus_req.addr, EVT_STATUS_ADDR)) begin
                s_d.evt_status = s_q.evt_status & ~bus_req.wdata[1:0];
            end
            if (hit(bus_req.addr, EVT_MASK_ADDR)) begin
                s_d.evt_mask = bus_req.wdata[1:0];
            end
            if (hit(bus_req.addr, CAUSE_ADDR)
                && bus_req.wdata[CAUSE_BIT]) begin
                s_d.cause = 1'b0;
            end
        end

        // events set after clears so a same-cycle set wins
        if (wr_service) begin
            s_d.evt_status[EVT_SERVICE] = 1'b1;
        end

        // timeout resets and sets the timeout event flag
        if (expire) begin
            s_d.cause                   = 1'b1;
            s_d.evt_status[EVT_TIMEOUT] = 1'b1;
            s_d.pin_oe                  = s_q.pin_func;
            s_d.reset_out               = 1'b1;
            s_d.pin_cnt                 = '0;
        end else if (s_q.pin_oe || s_q.reset_out) begin
            s_d.pin_cnt = s_q.pin_cnt + 1'b1;
            if (s_q.pin_cnt == 6'(PIN_LOW_CYCLES - 1)) begin
                s_d.pin_oe    = 1'b0;
                s_d.reset_out = 1'b0;
            end
        end

        if (mode.internal_reset || s_q.reset_out) begin
            s_d.pre        = '0;
            s_d.cnt        = '0;
            s_d.first_config_reg    = FIRST_CONFIG_REG_RESET;
            s_d.cfg_locked = 1'b0;
        end

        s_d.irq = |(s_d.evt_status & s_d.evt_mask);

        // one-cycle-late read data
        if (bus_req.rd) begin
            unique case (1'b1)
                rd_service:
                    s_d.rdata = reset_vector_lo;
                hit(bus_req.addr, FIRST_CONFIG_REG_ADDR):
                    s_d.rdata = s_q.first_config_reg;
                hit(bus_req.addr, PIN_CTRL_ADDR):
                    s_d.rdata = {7'h00, s_q.pin_func};
                hit(bus_req.addr, EVT_STATUS_ADDR):
                    s_d.rdata = {6'h00, s_q.evt_status};
                hit(bus_req.addr, EVT_MASK_ADDR):
                    s_d.rdata = {6'h00, s_q.evt_mask};
                hit(bus_req.addr, CAUSE_ADDR):
                    s_d.rdata = {7'h00, s_q.cause};
                default:
                    s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        bus_rdata    = s_q.rdata;
        wdog_reset   = s_q.reset_out;
        reset_pin_o  = 1'b0;
        reset_pin_oe = s_q.pin_oe;
        reset_cause  = s_q.cause;
        event_irq    = s_q.irq;
    end

endmodule : runaway_watchdog
`default_nettype wire

/* File: test/cpu_model.sv */
// cpu core model that drives the register port
`timescale 1ns/1ps
`default_nettype none
module cpu_model
    import runaway_watchdog_pkg::*;
(
    // clock
    input  wire logic        clk_sys,
    // register port
    output var  bus_req_type bus_req,
    input  wire logic [7:0]  bus_rdata
);
    initial bus_req = '0;

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        // data stands only in the cycle after the strobe; take it mid-cycle
        @(negedge clk_sys);
        v = bus_rdata;
    endtask : rd

    task automatic service();
        wr(SERVICE_ADDR, 8'h5A);
    endtask : service
endmodule : cpu_model
`default_nettype wire

/* File: test/runaway_watchdog_monitor.sv */
// concurrent checks on the runaway watchdog ports
`timescale 1ns/1ps
`default_nettype none
module runaway_watchdog_monitor
    import runaway_watchdog_pkg::*;
#(
    parameter int unsigned POR_CYCLES = POR_CLEAR_CYCLES
) (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // register port
    input wire bus_req_type bus_req,
    input wire logic [7:0]  bus_rdata,
    input wire logic [7:0]  reset_vector_lo,
    // modes
    input wire mode_type    mode,
    input wire logic        test_high_voltage,
    // outputs
    input wire logic        wdog_reset,
    input wire logic        reset_pin_o,
    input wire logic        reset_pin_oe,
    input wire logic        reset_cause,
    input wire logic        event_irq
);
    logic [5:0]  hi_q;
    int unsigned age_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // age cleared by reset, the reset pulse, internal reset and any service write
    always_ff @(posedge clk_sys) begin
        hi_q <= (rst || !wdog_reset) ? 6'h00 : hi_q + 6'h01;
        if (rst || wdog_reset || mode.internal_reset ||
            (bus_req.wr && bus_req.addr == SERVICE_ADDR))
            age_q <= 0;
        else
            age_q <= age_q + 1;
    end
    sequence stop_held;
        mode.stop_mode [*2];
    endsequence
    sequence monitor_held;
        (mode.monitor_mode && test_high_voltage) [*5];
    endsequence
    sequence break_held;
        (mode.monitor_mode && mode.break_active &&
         mode.break_watchdog_off) [*2];
    endsequence
    a_vector_read: assert property (bus_req.rd &&
        bus_req.addr == SERVICE_ADDR |=> bus_rdata == $past(reset_vector_lo))
        else $error("service read not vector byte");
    a_pulse_width: assert property ($fell(wdog_reset) |-> hi_q == 6'h20)
        else $error("reset pulse length wrong");
    a_pin_in_pulse: assert property (reset_pin_oe |-> wdog_reset)
        else $error("pin pulled outside reset");
    a_cause_set: assert property ($rose(wdog_reset) |-> reset_cause)
        else $error("cause bit not set");
    a_service_age: assert property ($rose(wdog_reset) |->
        age_q >= SHORT_TIMEOUT_CYCLES)
        else $error("reset too soon after service");
    a_stop_quiet: assert property (stop_held |=> !$rose(wdog_reset))
        else $error("reset during stop");
    a_monitor_quiet: assert property (monitor_held |=> !$rose(wdog_reset))
        else $error("reset in monitor test mode");
    a_break_quiet: assert property (break_held |=> !$rose(wdog_reset))
        else $error("reset during break");
endmodule : runaway_watchdog_monitor
bind runaway_watchdog runaway_watchdog_monitor #(.POR_CYCLES(POR_CYCLES))
    runaway_watchdog_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata),
    .reset_vector_lo(reset_vector_lo), .mode(mode),
    .test_high_voltage(test_high_voltage), .wdog_reset(wdog_reset),
    .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
    .reset_cause(reset_cause), .event_irq(event_irq));
`default_nettype wire

/* File: test/runaway_watchdog_tb.sv */
// self-checking bench for the runaway watchdog
`timescale 1ns/1ps
`default_nettype none
module runaway_watchdog_tb
    import runaway_watchdog_pkg::*;
();
    typedef struct packed {
        logic        w;
        logic [15:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
    } row_type;
    logic        clk_sys;
    logic        rst;
    bus_req_type bus_req;
    logic [7:0]  bus_rdata;
    logic [7:0]  d;
    mode_type    mode;
    logic        hv;
    logic        wdog_reset;
    logic        pin_oe;
    logic        pin_o;
    logic        cause;
    logic        irq;
    int          errors;
    int          samples_checked;
    int          cyc;
    // write flag, address, data, expected read back
    row_type rows [7] = '{
        '{1'b0, SERVICE_ADDR, 8'h00, 8'hA5},
        '{1'b1, EVT_MASK_ADDR, 8'h03, 8'h03},
        '{1'b1, PIN_CTRL_ADDR, 8'h01, 8'h01},
        '{1'b1, 16'h0050, 8'hFF, 8'h00},
        '{1'b1, FIRST_CONFIG_REG_ADDR, 8'h81, 8'h81},
        '{1'b1, FIRST_CONFIG_REG_ADDR, 8'h80, 8'h81},
        '{1'b0, CAUSE_ADDR, 8'h00, 8'h00}};

    runaway_watchdog #(.POR_CYCLES(16)) runaway_watchdog_inst (
        .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .reset_vector_lo(8'hA5), .mode(mode),
        .test_high_voltage(hv), .wdog_reset(wdog_reset), .reset_pin_o(pin_o),
        .reset_pin_oe(pin_oe), .reset_cause(cause), .event_irq(irq));
    cpu_model cpu_model_inst (.clk_sys(clk_sys), .bus_req(bus_req),
        .bus_rdata(bus_rdata));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, g, e);
        end
    endtask : chk

    task automatic results();
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic quiet(input int c);
        logic hit;
        hit = 1'b0;
        repeat (c) @(posedge clk_sys) hit = hit | wdog_reset;
        chk(hit, 0);
    endtask : quiet

    // service, then time the expiry and the pulse
    task automatic expire();
        int n;
        n = 0;
        cpu_model_inst.service();
        while (wdog_reset !== 1'b1 && n < 9000) @(posedge clk_sys) n++;
        chk(n >= 8176 && n <= 8196, 1);
        chk(pin_oe, 1);
        chk(pin_o, 0);
        n = 0;
        while (wdog_reset === 1'b1 && n < 40) @(posedge clk_sys) n++;
        chk(32'(n), 32);
    endtask : expire

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        cyc = 0;
        forever begin
            @(posedge clk_sys);
            cyc++;
            if (cyc == 90000) begin
                errors++;
                results();
            end
        end
    end

    initial begin
        rst = 1'b1;
        mode = '0;
        hv = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w)
                cpu_model_inst.wr(rows[i].a, rows[i].d);
            cpu_model_inst.rd(rows[i].a, d);
            chk(d, rows[i].e);
        end
        cpu_model_inst.service();
        quiet(9000);
        chk(irq, 1);
        cpu_model_inst.wr(EVT_MASK_ADDR, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk(irq, 0);
        cpu_model_inst.wr(EVT_STATUS_ADDR, 8'h02);
        cpu_model_inst.wr(EVT_MASK_ADDR, 8'h03);
        repeat (2) @(posedge clk_sys);
        chk(irq, 0);
        mode.internal_reset <= 1'b1;
        @(posedge clk_sys);
        mode.internal_reset <= 1'b0;
        cpu_model_inst.wr(FIRST_CONFIG_REG_ADDR, 8'h80);
        cpu_model_inst.rd(FIRST_CONFIG_REG_ADDR, d);
        chk(d, 8'h80);
        mode.wait_mode <= 1'b1;
        expire();
        cpu_model_inst.rd(CAUSE_ADDR, d);
        chk(d, 8'h01);
        cpu_model_inst.wr(FIRST_CONFIG_REG_ADDR, 8'h80);
        mode.stop_mode <= 1'b1;
        quiet(9000);
        mode.stop_mode <= 1'b0;
        cpu_model_inst.service();
        mode.monitor_mode <= 1'b1;
        hv <= 1'b1;
        quiet(9000);
        hv <= 1'b0;
        mode.break_active <= 1'b1;
        mode.break_watchdog_off <= 1'b1;
        quiet(9000);
        mode <= '0;
        expire();
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        cpu_model_inst.rd(CAUSE_ADDR, d);
        chk(d, 8'h00);
        results();
    end
endmodule : runaway_watchdog_tb
`default_nettype wire
